// ==== pkg/hpc_pkg.sv ====
// hpc_pkg: constants and carrier types of the host control pin select block
package hpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] REG_PIN_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PIN_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] REG_HOST_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] REG_BYTE_ERR = 4'h3;

  // pin config fields (dir bit 1 = output)
  localparam int CFG_DIR44_BIT = 0;
  localparam int CFG_DIR45_BIT = 1;
  localparam int CFG_OUT44_BIT = 4;
  localparam int CFG_OUT45_BIT = 5;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;

  // pin status fields
  localparam int STAT_HOST_BIT = 0;
  localparam int STAT_OFF_BIT = 1;
  localparam int STAT_IN44_BIT = 2;
  localparam int STAT_IN45_BIT = 3;
  localparam int STAT_SEL_LSB = 4;
  localparam int STAT_SECOND_BIT = 6;

  // byte order error fields
  localparam int ERR_ORDER_BIT = 0;

  localparam logic [DATA_W-1:0] ADDR_RESET = 16'h0000;

  // off mode pin levels
  localparam logic OFF_TRST_LVL = 1'b0;
  localparam logic OFF_EMULATION_PIN_0_LVL = 1'b1;
  localparam logic OFF_EMU1_LVL = 1'b0;

  // access select codes
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDRESS = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    TGT_CONTROL,
    TGT_DATA_INC,
    TGT_ADDRESS,
    TGT_DATA
  } hpc_target_t;

  typedef enum logic [1:0] {
    MODE_IN_RESET,
    MODE_PIO,
    MODE_HOST
  } hpc_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } hpc_reg_req_t;

  typedef struct packed {
    logic test_rst_n;
    logic emulation_pin_0;
    logic emulation_off_pin;
  } hpc_dbg_t;

  typedef struct packed {
    logic host_chip_select_n;
    logic access_sel_1;
    logic access_sel_0;
    logic [7:0] host_shared_bus;
  } hpc_host_in_t;

  typedef struct packed {
    logic o;
    logic oe_n;
  } hpc_pin_drv_t;

endpackage

// ==== tb/hpc_host_model.sv ====
// behavioural host processor on the multiplexed byte-wide host port
`timescale 1ns/1ps

module hpc_host_model (
  // clock
  input wire logic sys_clk,
  // host pins
  output logic pin_a,
  output logic pin_b,
  output hpc_pkg::hpc_host_in_t host_in
);
  initial begin
    pin_a = 1'b1;
    pin_b = 1'b0;
    host_in = 11'h4a5;
  end
  ////////////////////////////////////////
  task set_b(input logic v);
    pin_b <= v;
  endtask
  // each level held 4 cycles so the two-stage sync sees it
  task send_byte(input logic [7:0] b, input logic ident);
    pin_b <= ident;
    host_in.host_shared_bus <= b;
    repeat (4) @(posedge sys_clk);
    pin_a <= 1'b0;
    repeat (4) @(posedge sys_clk);
    pin_a <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  task send_addr(input logic [1:0] sel, input logic [15:0] a, input logic cs_n);
    @(posedge sys_clk);
    host_in.host_chip_select_n <= cs_n;
    {host_in.access_sel_1, host_in.access_sel_0} <= sel;
    send_byte(a[15:8], 1'b0);
    send_byte(a[7:0], 1'b1);
    host_in.host_chip_select_n <= 1'b1;
    // a released bus does not keep its last value
    host_in.host_shared_bus <= ~a[7:0];
  endtask
  // second byte with no first byte before it, to provoke an order error
  task send_lone(input logic [7:0] b);
    @(posedge sys_clk);
    host_in.host_chip_select_n <= 1'b0;
    send_byte(b, 1'b1);
    host_in.host_chip_select_n <= 1'b1;
  endtask
endmodule

// ==== tb/hpc_pin_select_sva.sv ====
// port assertions of the host control pin select block
`timescale 1ns/1ps

module hpc_sva_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // pins
  input wire hpc_pkg::hpc_dbg_t dbg_pins,
  input wire hpc_pkg::hpc_host_in_t host_in,
  input wire logic host_ctrl_pin_a_oe_n,
  input wire logic host_ctrl_pin_b_oe_n,
  input wire logic host_ready_out_o,
  input wire logic host_ready_out_oe_n,
  // decoded view
  input wire logic host_mode,
  input wire hpc_pkg::hpc_target_t host_target,
  input wire logic addr_captured
);
  default clocking cb @(posedge sys_clk); endclocking
  logic [1:0] rel_cnt;
  logic [2:0] off_cnt;
  logic [2:0] on_cnt;
  logic is_off;
  logic [1:0] sel;
  assign is_off = dbg_pins == {hpc_pkg::OFF_TRST_LVL, hpc_pkg::OFF_EMULATION_PIN_0_LVL, hpc_pkg::OFF_EMU1_LVL};
  assign sel = {host_in.access_sel_1, host_in.access_sel_0};
  ////////////////////////////////////////
  // counters leave room for two sync stages plus the output register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rel_cnt <= 2'h0;
    end else if (rel_cnt != 2'h3) begin
      rel_cnt <= rel_cnt + 2'h1;
    end
    off_cnt <= !is_off ? 3'h0 : (off_cnt == 3'h4 ? off_cnt : off_cnt + 3'h1);
    on_cnt <= (is_off || sys_rst) ? 3'h0 : (on_cnt == 3'h4 ? on_cnt : on_cnt + 3'h1);
  end
  a_reset_float: assert property (sys_rst |=> host_ctrl_pin_a_oe_n && host_ctrl_pin_b_oe_n && host_ready_out_oe_n)
    else $error("pins driven in reset");
  a_pio_inputs: assert property (sys_rst ##1 !sys_rst |-> (host_ctrl_pin_a_oe_n && host_ctrl_pin_b_oe_n) [*2])
    else $error("pin driven after reset");
  a_mode_held: assert property (disable iff (sys_rst) rel_cnt == 2'h3 |-> $stable(host_mode))
    else $error("mode moved after reset");
  a_ready_drive: assert property (disable iff (sys_rst)
    rel_cnt == 2'h3 && on_cnt == 3'h4 |-> host_ready_out_o && !host_ready_out_oe_n)
    else $error("ready not driven high");
  a_off_float: assert property (disable iff (sys_rst)
    off_cnt == 3'h4 |-> host_ctrl_pin_a_oe_n && host_ctrl_pin_b_oe_n && host_ready_out_oe_n)
    else $error("pin driven in off mode");
  a_host_inputs: assert property (disable iff (sys_rst)
    host_mode |-> host_ctrl_pin_a_oe_n && host_ctrl_pin_b_oe_n)
    else $error("host pin driven");
  a_capture_pulse: assert property (disable iff (sys_rst) addr_captured |-> host_mode ##1 !addr_captured)
    else $error("bad capture pulse");
  a_target_decode: assert property (disable iff (sys_rst)
    (host_mode && !host_in.host_chip_select_n && $stable(sel)) [*4]
    |-> host_target == hpc_pkg::hpc_target_t'(sel))
    else $error("wrong target");
  c_capture: cover property (addr_captured);
  c_off: cover property (off_cnt == 3'h4);
  c_host: cover property (rel_cnt == 2'h3 && host_mode);
endmodule

bind hpc_pin_select hpc_sva_chk u_hpc_sva_chk (.sys_clk, .sys_rst, .dbg_pins, .host_in,
  .host_ctrl_pin_a_oe_n, .host_ctrl_pin_b_oe_n, .host_ready_out_o, .host_ready_out_oe_n,
  .host_mode, .host_target, .addr_captured);

// ==== tb/hpc_pin_select_tb.sv ====
// self-checking bench of the host control pin select block
`timescale 1ns/1ps

module hpc_pin_select_tb;
  `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
  logic sys_clk, sys_rst, boot_strap_input, host_a, host_b, pin_a_i, pin_b_i;
  logic pin_a_o, pin_a_oe_n, pin_b_o, pin_b_oe_n, rdy_o, rdy_oe_n, host_mode, addr_captured;
  hpc_pkg::hpc_dbg_t dbg_pins;
  hpc_pkg::hpc_reg_req_t reg_req;
  hpc_pkg::hpc_host_in_t host_in;
  hpc_pkg::hpc_target_t host_target;
  hpc_pkg::hpc_target_t exp_tgt [4];
  logic [15:0] reg_rdata, rd_val, addr;
  logic [1:0] rv;
  int bad_count, cmp_count, cyc, seed, n_cap, n0;
  assign pin_a_i = pin_a_oe_n ? host_a : pin_a_o;
  assign pin_b_i = pin_b_oe_n ? host_b : pin_b_o;
  hpc_host_model u_hpc_host_model (.sys_clk, .pin_a(host_a), .pin_b(host_b), .host_in);
  hpc_pin_select u_hpc_pin_select (.sys_clk, .sys_rst, .boot_strap_input, .dbg_pins,
    .host_ctrl_pin_a_i(pin_a_i), .host_ctrl_pin_a_o(pin_a_o), .host_ctrl_pin_a_oe_n(pin_a_oe_n),
    .host_ctrl_pin_b_i(pin_b_i), .host_ctrl_pin_b_o(pin_b_o), .host_ctrl_pin_b_oe_n(pin_b_oe_n),
    .host_in, .host_ready_out_o(rdy_o), .host_ready_out_oe_n(rdy_oe_n), .host_mode,
    .host_target, .addr_captured, .reg_req, .reg_rdata);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (addr_captured === 1'b1) n_cap <= n_cap + 1;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end
  task reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= {a, d, 2'h2};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask
  task reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= {a, 16'h0000, 2'h1};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // the strap moves after release so a late change would show
  task do_reset(input logic strap);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    boot_strap_input <= strap;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    boot_strap_input <= ~strap;
    repeat (4) @(posedge sys_clk);
  endtask
  initial begin
    seed = 66675;
    sys_rst = 1'b1;
    boot_strap_input = 1'b0;
    dbg_pins = 3'h5;
    reg_req = 22'h000000;
    {bad_count, cmp_count, cyc, n_cap} = 128'h0;
    exp_tgt = '{hpc_pkg::TGT_CONTROL, hpc_pkg::TGT_DATA_INC, hpc_pkg::TGT_ADDRESS, hpc_pkg::TGT_DATA};
    do_reset(1'b0);
    `CHK(host_mode, 1'b0)
    `CHK({pin_a_oe_n, pin_b_oe_n, rdy_o, rdy_oe_n}, 4'he)
    addr = $random(seed);
    n0 = n_cap;
    u_hpc_host_model.send_addr(2'h2, addr, 1'b0);
    reg_rd(hpc_pkg::REG_HOST_ADDR, rd_val);
    `CHK({rd_val, n_cap}, {16'h0000, n0})
    rv = $random(seed);
    reg_wr(hpc_pkg::REG_PIN_CFG, 16'h0001 | (16'(rv[0]) << hpc_pkg::CFG_OUT44_BIT));
    u_hpc_host_model.set_b(rv[1]);
    repeat (4) @(posedge sys_clk);
    `CHK({pin_a_oe_n, pin_a_o, pin_b_oe_n}, {1'b0, rv[0], 1'b1})
    reg_rd(hpc_pkg::REG_PIN_STAT, rd_val);
    `CHK(rd_val[hpc_pkg::STAT_IN45_BIT], rv[1])
    dbg_pins <= {hpc_pkg::OFF_TRST_LVL, hpc_pkg::OFF_EMULATION_PIN_0_LVL, hpc_pkg::OFF_EMU1_LVL};
    repeat (5) @(posedge sys_clk);
    `CHK({pin_a_oe_n, pin_b_oe_n, rdy_oe_n}, 3'h7)
    dbg_pins <= 3'h5;
    $display("test io mode done");
    do_reset(1'b1);
    `CHK(host_mode, 1'b1)
    reg_wr(hpc_pkg::REG_PIN_CFG, 16'h0033);
    repeat (3) @(posedge sys_clk);
    `CHK({pin_a_oe_n, pin_b_oe_n, rdy_o, rdy_oe_n}, 4'he)
    for (int i = 0; i < 4; i++) begin
      addr = $random(seed);
      n0 = n_cap;
      u_hpc_host_model.send_addr(i[1:0], addr, 1'b0);
      `CHK(host_target, exp_tgt[i])
      reg_rd(hpc_pkg::REG_HOST_ADDR, rd_val);
      `CHK({rd_val, n_cap}, {addr, n0 + 1})
    end
    u_hpc_host_model.send_addr(2'h2, ~addr, 1'b1);
    reg_rd(hpc_pkg::REG_HOST_ADDR, rd_val);
    `CHK({rd_val, n_cap}, {addr, n0 + 1})
    u_hpc_host_model.send_lone(addr[7:0]);
    reg_rd(hpc_pkg::REG_BYTE_ERR, rd_val);
    `CHK(rd_val, 16'h0001)
    reg_wr(hpc_pkg::REG_BYTE_ERR, 16'h0001);
    reg_rd(hpc_pkg::REG_BYTE_ERR, rd_val);
    `CHK(rd_val, 16'h0000)
    reg_rd(hpc_pkg::REG_PIN_STAT, rd_val);
    `CHK(rd_val[hpc_pkg::STAT_HOST_BIT +: 2], 2'h1)
    reg_rd(4'hf, rd_val);
    `CHK(rd_val, 16'h0000)
    $display("test host mode done");
    final_report();
  end
endmodule

// ==== verilog/hpc_pin_select.sv ====
// hpc_pin_select: reset-time function select and host strobes of the host control pins
//
// Contract
// - strap low at reset: pin a becomes parallel io bit 44.
// - strap high at reset: pin a becomes the host address strobe.
// - strap low at reset: pin b becomes parallel io bit 45.
// - strap high at reset: pin b becomes the host byte identification input.
// - pin functions fixed when reset releases and held afterwards.
// - io bit 44 leaves reset as an input.
// - io bit 45 leaves reset as an input.
// - address strobe is an input after reset.
// - byte identification is an input after reset.
// - address strobe captures the presented address into the host address register.
// - address strobe works only in multiplexed host mode.
// - four access select states choose control, data-inc, address or data register.
// - host control pins float while the device is in off mode.
// - each multiplexed host cycle is two consecutive byte transfers.
// - ready floats in reset and in off mode, drives one otherwise.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps

module hpc_pin_select (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // strap and debug pins
  input wire logic boot_strap_input,
  input wire hpc_pkg::hpc_dbg_t dbg_pins,
  // host control pin a
  input wire logic host_ctrl_pin_a_i,
  output logic host_ctrl_pin_a_o,
  output logic host_ctrl_pin_a_oe_n,
  // host control pin b
  input wire logic host_ctrl_pin_b_i,
  output logic host_ctrl_pin_b_o,
  output logic host_ctrl_pin_b_oe_n,
  // other host pins
  input wire hpc_pkg::hpc_host_in_t host_in,
  output logic host_ready_out_o,
  output logic host_ready_out_oe_n,
  // decoded host view
  output logic host_mode,
  output hpc_pkg::hpc_target_t host_target,
  output logic addr_captured,
  // register port
  input wire hpc_pkg::hpc_reg_req_t reg_req,
  output logic [hpc_pkg::DATA_W-1:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // decode of the access select pins, shared by status and the host_target output
  function automatic hpc_pkg::hpc_target_t decode_target(input logic [1:0] sel);
    hpc_pkg::hpc_target_t t;
    t = hpc_pkg::TGT_CONTROL;
    case (sel)
      hpc_pkg::SEL_CONTROL: t = hpc_pkg::TGT_CONTROL;
      hpc_pkg::SEL_DATA_INC: t = hpc_pkg::TGT_DATA_INC;
      hpc_pkg::SEL_ADDRESS: t = hpc_pkg::TGT_ADDRESS;
      hpc_pkg::SEL_DATA: t = hpc_pkg::TGT_DATA;
      default: t = hpc_pkg::TGT_CONTROL;
    endcase
    return t;
  endfunction

  function automatic logic [1:0] target_code(input hpc_pkg::hpc_target_t t);
    logic [1:0] c;
    c = hpc_pkg::SEL_CONTROL;
    case (t)
      hpc_pkg::TGT_CONTROL: c = hpc_pkg::SEL_CONTROL;
      hpc_pkg::TGT_DATA_INC: c = hpc_pkg::SEL_DATA_INC;
      hpc_pkg::TGT_ADDRESS: c = hpc_pkg::SEL_ADDRESS;
      hpc_pkg::TGT_DATA: c = hpc_pkg::SEL_DATA;
      default: c = hpc_pkg::SEL_CONTROL;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // whole module state
  typedef struct packed {
    // two-stage synchronisers for pins from outside the clock domain
    logic strap_s1;
    logic strap_s2;
    logic [2:0] dbg_s1;
    logic [2:0] dbg_s2;
    logic pa_s1;
    logic pa_s2;
    logic pa_s3;
    logic pb_s1;
    logic pb_s2;
    logic [10:0] hin_s1;
    logic [10:0] hin_s2;
    // mode and pin control
    hpc_pkg::hpc_mode_t mode;
    // latched host mode kept as its own flop so the output needs no decode
    logic host_flag;
    logic off;
    logic [hpc_pkg::DATA_W-1:0] cfg;
    hpc_pkg::hpc_pin_drv_t pin_a;
    hpc_pkg::hpc_pin_drv_t pin_b;
    hpc_pkg::hpc_pin_drv_t ready;
    // host side
    hpc_pkg::hpc_target_t target;
    logic second_byte;
    logic [hpc_pkg::DATA_W-1:0] host_addr;
    logic captured;
    logic order_err;
    // register read data
    logic [hpc_pkg::DATA_W-1:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // combinational helpers
  hpc_pkg::hpc_host_in_t hin;
  logic off_now;
  logic strobe_fall;
  logic host_cycle;
  logic order_fault;
  logic [hpc_pkg::DATA_W-1:0] stat_word;

  always_comb begin
    hin = hpc_pkg::hpc_host_in_t'(st_reg.hin_s2);
    off_now = (st_reg.dbg_s2[2] == hpc_pkg::OFF_TRST_LVL) &&
      (st_reg.dbg_s2[1] == hpc_pkg::OFF_EMULATION_PIN_0_LVL) &&
      (st_reg.dbg_s2[0] == hpc_pkg::OFF_EMU1_LVL);
    // strobe is active low; only a falling edge starts a byte capture
    strobe_fall = st_reg.pa_s3 && !st_reg.pa_s2;
    // chip select gates every host access
    host_cycle = (st_reg.mode == hpc_pkg::MODE_HOST) && !hin.host_chip_select_n;
    // a byte whose ident does not match the pending half breaks the pairing
    order_fault = host_cycle && strobe_fall && (st_reg.pb_s2 != st_reg.second_byte);
    stat_word = '0;
    stat_word[hpc_pkg::STAT_HOST_BIT] = (st_reg.mode == hpc_pkg::MODE_HOST);
    stat_word[hpc_pkg::STAT_OFF_BIT] = st_reg.off;
    stat_word[hpc_pkg::STAT_IN44_BIT] = st_reg.pa_s2;
    stat_word[hpc_pkg::STAT_IN45_BIT] = st_reg.pb_s2;
    stat_word[hpc_pkg::STAT_SEL_LSB +: 2] = target_code(st_reg.target);
    stat_word[hpc_pkg::STAT_SECOND_BIT] = st_reg.second_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;

    // synchronisers: first stage feeds only the second
    st_next.strap_s1 = boot_strap_input;
    st_next.strap_s2 = st_reg.strap_s1;
    st_next.dbg_s1 = {dbg_pins.test_rst_n, dbg_pins.emulation_pin_0,
      dbg_pins.emulation_off_pin};
    st_next.dbg_s2 = st_reg.dbg_s1;
    st_next.pa_s1 = host_ctrl_pin_a_i;
    st_next.pa_s2 = st_reg.pa_s1;
    st_next.pa_s3 = st_reg.pa_s2;
    st_next.pb_s1 = host_ctrl_pin_b_i;
    st_next.pb_s2 = st_reg.pb_s1;
    st_next.hin_s1 = host_in;
    st_next.hin_s2 = st_reg.hin_s1;
    st_next.off = off_now;
    st_next.rdata = '0;

    case (st_reg.mode)
      hpc_pkg::MODE_IN_RESET: begin
        // strap read only now; later pin changes cannot move the choice
        if (st_reg.strap_s2) begin
          st_next.mode = hpc_pkg::MODE_HOST;
        end else begin
          st_next.mode = hpc_pkg::MODE_PIO;
        end
      end
      hpc_pkg::MODE_PIO: begin
        st_next.mode = hpc_pkg::MODE_PIO;
      end
      hpc_pkg::MODE_HOST: begin
        st_next.mode = hpc_pkg::MODE_HOST;
      end
      default: begin
        st_next.mode = hpc_pkg::MODE_IN_RESET;
      end
    endcase

    // pin drivers
    st_next.ready.o = 1'b1;
    st_next.ready.oe_n = 1'b0;
    if (st_reg.mode == hpc_pkg::MODE_PIO) begin
      st_next.pin_a.o = st_reg.cfg[hpc_pkg::CFG_OUT44_BIT];
      st_next.pin_a.oe_n = !st_reg.cfg[hpc_pkg::CFG_DIR44_BIT];
      st_next.pin_b.o = st_reg.cfg[hpc_pkg::CFG_OUT45_BIT];
      st_next.pin_b.oe_n = !st_reg.cfg[hpc_pkg::CFG_DIR45_BIT];
    end else begin
      // host strobes are pure inputs
      st_next.pin_a.o = 1'b0;
      st_next.pin_a.oe_n = 1'b1;
      st_next.pin_b.o = 1'b0;
      st_next.pin_b.oe_n = 1'b1;
    end
    if (off_now) begin
      st_next.pin_a.oe_n = 1'b1;
      st_next.pin_b.oe_n = 1'b1;
      st_next.ready.oe_n = 1'b1;
    end

    // host side: target decode and two-byte address capture
    st_next.captured = 1'b0;
    if (host_cycle) begin
      st_next.target = decode_target({hin.access_sel_1, hin.access_sel_0});
    end
    if (host_cycle && strobe_fall) begin
      if (!st_reg.pb_s2) begin
        // first byte carries the upper half
        st_next.host_addr[15:8] = hin.host_shared_bus;
        st_next.second_byte = 1'b1;
        // a first byte while one is pending means the host lost a pairing
        if (st_reg.second_byte) begin
          st_next.order_err = 1'b1;
        end
      end else begin
        st_next.host_addr[7:0] = hin.host_shared_bus;
        st_next.second_byte = 1'b0;
        st_next.captured = st_reg.second_byte;
        // a second byte with no first byte before it breaks the pairing
        if (!st_reg.second_byte) begin
          st_next.order_err = 1'b1;
        end
      end
    end

    // register writes; error clear is write-one, and a new error wins
    if (reg_req.wr) begin
      case (reg_req.addr)
        hpc_pkg::REG_PIN_CFG: begin
          st_next.cfg = reg_req.wdata;
        end
        hpc_pkg::REG_BYTE_ERR: begin
          if (reg_req.wdata[hpc_pkg::ERR_ORDER_BIT] && !order_fault) begin
            st_next.order_err = 1'b0;
          end
        end
        default: begin
          st_next.cfg = st_reg.cfg;
        end
      endcase
    end

    // register reads: data stands in the next cycle only
    if (reg_req.rd) begin
      case (reg_req.addr)
        hpc_pkg::REG_PIN_CFG: st_next.rdata = st_reg.cfg;
        hpc_pkg::REG_PIN_STAT: st_next.rdata = stat_word;
        hpc_pkg::REG_HOST_ADDR: st_next.rdata = st_reg.host_addr;
        hpc_pkg::REG_BYTE_ERR: begin
          st_next.rdata = '0;
          st_next.rdata[hpc_pkg::ERR_ORDER_BIT] = st_reg.order_err;
        end
        default: st_next.rdata = '0;
      endcase
    end

    // reset: constants only, synchronisers keep running for the strap
    if (sys_rst) begin
      st_next.mode = hpc_pkg::MODE_IN_RESET;
      st_next.cfg = hpc_pkg::CFG_RESET;
      st_next.pin_a = '{o: 1'b0, oe_n: 1'b1};
      st_next.pin_b = '{o: 1'b0, oe_n: 1'b1};
      st_next.ready = '{o: 1'b0, oe_n: 1'b1};
      st_next.target = hpc_pkg::TGT_CONTROL;
      st_next.second_byte = 1'b0;
      st_next.host_addr = hpc_pkg::ADDR_RESET;
      st_next.captured = 1'b0;
      st_next.order_err = 1'b0;
      st_next.rdata = '0;
    end

    // follows the mode of the same edge, so reset clears it too
    st_next.host_flag = (st_next.mode == hpc_pkg::MODE_HOST);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign host_ctrl_pin_a_o = st_reg.pin_a.o;
  assign host_ctrl_pin_a_oe_n = st_reg.pin_a.oe_n;
  assign host_ctrl_pin_b_o = st_reg.pin_b.o;
  assign host_ctrl_pin_b_oe_n = st_reg.pin_b.oe_n;
  assign host_ready_out_o = st_reg.ready.o;
  assign host_ready_out_oe_n = st_reg.ready.oe_n;
  assign host_mode = st_reg.host_flag;
  assign host_target = st_reg.target;
  assign addr_captured = st_reg.captured;
  assign reg_rdata = st_reg.rdata;

endmodule
